//--- core/rung_pkg.sv
// shared constants and instruction codes of the rung evaluator
package rung_pkg;
	localparam int WORD_W      = 16;  // comparison operand width
	localparam int POINT_AW    = 8;   // point address width
	localparam int NUM_POINTS  = 256; // discrete points in the image
	localparam int PHYS_OUTS   = 8;   // physical output points
	localparam int PAUSE_LAST  = 7;   // highest point a pause may name
	localparam int STACK_DEPTH = 8;   // logic stack entries

	localparam logic [PHYS_OUTS-1:0] OUTS_RESET  = 8'h00;
	localparam logic [PHYS_OUTS-1:0] PAUSE_RESET = 8'h00;

	typedef enum logic [3:0] {
		OP_NOP,
		OP_START_IF_MATCH,
		OP_START_IF_MISMATCH,
		OP_PARALLEL_IF_MATCH,
		OP_PARALLEL_IF_MISMATCH,
		OP_SERIES_IF_MATCH,
		OP_SERIES_IF_MISMATCH,
		OP_START_IF_ATLEAST,
		OP_START_IF_BELOW,
		OP_PARALLEL_IF_ATLEAST,
		OP_COIL_OUT,
		OP_PARALLEL_COIL_DRIVE,
		OP_RISING_EDGE_PULSE,
		OP_LATCH_SET,
		OP_LATCH_CLEAR,
		OP_OUTPUT_PAUSE
	} op_e;
endpackage

//--- core/point_memory.sv
// discrete point image with range write and registered read
`timescale 1ns/1ps
`default_nettype none
module point_memory
	import rung_pkg::*;
#(
	parameter int AW = POINT_AW,
	parameter int N  = NUM_POINTS
)(
	input  wire logic          clk_i,
	input  wire logic          rst_n_i,
	input  wire logic          ce_i,
	input  wire logic          wr_i,
	input  wire logic [AW-1:0] wr_lo_i,
	input  wire logic [AW-1:0] wr_hi_i,
	input  wire logic          wr_val_i,
	input  wire logic [AW-1:0] rd_addr_i,
	output logic               rd_bit_o,
	output logic [N-1:0]       bits_o
);
	logic [N-1:0] next_bits;
	logic         next_rd;

	// every entry inside lo..hi takes the value; empty if hi is below lo
	genvar i;
	generate
		for (i = 0; i < N; i++)
		begin : g_entry
			assign next_bits[i] = (wr_i && (AW'(i) >= wr_lo_i) &&
				(AW'(i) <= wr_hi_i)) ? wr_val_i : bits_o[i];
		end
	endgenerate

	// read shows the image before this cycle's write
	always_comb
	begin
		next_rd = bits_o[rd_addr_i];
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			bits_o   <= '0;
			rd_bit_o <= 1'b0;
		end
		else if (ce_i)
		begin
			bits_o   <= next_bits;
			rd_bit_o <= next_rd;
		end
	end
endmodule // point_memory
`default_nettype wire

//--- core/logic_stack.sv
// rung logic stack with overflow detection
`timescale 1ns/1ps
`default_nettype none
module logic_stack
	import rung_pkg::*;
#(
	parameter int DEPTH = STACK_DEPTH
)(
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	input  wire logic ce_i,
	input  wire logic start_i,
	input  wire logic par_i,
	input  wire logic ser_i,
	input  wire logic coil_i,
	input  wire logic term_i,
	input  wire logic clear_err_i,
	output logic      top_o,
	output logic      err_o
);
	localparam int DW = $clog2(DEPTH + 1);

	logic [DEPTH-1:0] bits;
	logic [DW-1:0]    depth;
	logic             closed;
	logic [DEPTH-1:0] next_bits;
	logic [DW-1:0]    next_depth;
	logic             next_closed;
	logic             next_err;

	assign top_o = bits[0];

	// a start after a coil opens a fresh rung; otherwise it pushes a branch, or flags overflow when the stack is full
	always_comb
	begin
		next_bits   = bits;
		next_depth  = depth;
		next_closed = closed;
		next_err    = clear_err_i ? 1'b0 : err_o;
		if (start_i)
		begin
			if (closed)
			begin
				next_bits    = '0;
				next_bits[0] = term_i;
				next_depth   = DW'(1);
				next_closed  = 1'b0;
			end
			else if (depth == DW'(DEPTH))
				next_err = 1'b1;
			else
			begin
				next_bits  = {bits[DEPTH-2:0], term_i};
				next_depth = depth + DW'(1);
			end
		end
		if (par_i)
			next_bits[0] = bits[0] | term_i;
		if (ser_i)
			next_bits[0] = bits[0] & term_i;
		if (coil_i)
			next_closed = 1'b1;
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			bits   <= '0;
			depth  <= '0;
			closed <= 1'b1;
			err_o  <= 1'b0;
		end
		else if (ce_i)
		begin
			bits   <= next_bits;
			depth  <= next_depth;
			closed <= next_closed;
			err_o  <= next_err;
		end
	end

	stack_over_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(ce_i && start_i && !closed && depth == DW'(DEPTH)) |=> err_o)
		else $error("stack overflow not flagged");
endmodule // logic_stack
`default_nettype wire

//--- core/ladder_rung_evaluator.sv
// scan based rung evaluator: comparative contacts and discrete coils
`timescale 1ns/1ps
`default_nettype none
module ladder_rung_evaluator
	import rung_pkg::*;
#(
	parameter int WW = WORD_W,
	parameter int AW = POINT_AW,
	parameter int N  = NUM_POINTS,
	parameter int NO = PHYS_OUTS
)(
	input  wire logic          clk_i,
	input  wire logic          resetn_i,
	input  wire logic          ce_i,
	input  wire logic          scan_start_i,
	input  wire logic          scan_end_i,
	input  wire logic          instr_valid_i,
	input  wire op_e           op_i,
	input  wire logic [WW-1:0] operand_a_i,
	input  wire logic [WW-1:0] operand_b_i,
	input  wire logic [AW-1:0] point_i,
	input  wire logic          range_en_i,
	input  wire logic [AW-1:0] range_end_i,
	input  wire logic [NO-1:0] override_i,
	input  wire logic [AW-1:0] image_addr_i,
	output logic               image_bit_o,
	output logic [NO-1:0]      outputs_o,
	output logic               rung_o,
	output logic               stack_error_o,
	output logic               operand_error_o
);
	// reset release through two flops; assertion is immediate
	logic rst_meta;
	logic rst_n;

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end
		else
		begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	logic          take;
	logic          eq;
	logic          ge;
	logic          term;
	logic          st_start;
	logic          st_par;
	logic          st_ser;
	logic          st_coil;
	logic          top;
	logic          wr;
	logic [AW-1:0] wr_lo;
	logic [AW-1:0] wr_hi;
	logic          wr_val;
	logic [AW-1:0] hi_pt;
	logic [N-1:0]  img;
	logic [N-1:0]  or_acc;
	logic [N-1:0]  next_or_acc;
	logic [N-1:0]  prev_rung;
	logic [N-1:0]  next_prev_rung;
	logic [NO-1:0] pause_acc;
	logic [NO-1:0] next_pause_acc;
	logic [NO-1:0] pause_hit;
	logic [NO-1:0] next_outputs;
	logic          next_operand_error;

	assign take  = instr_valid_i;
	assign hi_pt = range_en_i ? range_end_i : point_i;
	assign rung_o = top;

	// plain unsigned compares; timer and counter values arrive as words
	assign eq = (operand_a_i == operand_b_i);
	assign ge = (operand_a_i >= operand_b_i);

	// contact term and the stack action each comparative form asks for
	always_comb
	begin
		term     = 1'b0;
		st_start = 1'b0;
		st_par   = 1'b0;
		st_ser   = 1'b0;
		st_coil  = 1'b0;
		if (take)
		begin
			unique case (op_i)
				OP_NOP:                  ;
				OP_START_IF_MATCH:       begin term = eq;  st_start = 1'b1; end
				OP_START_IF_MISMATCH:    begin term = !eq; st_start = 1'b1; end
				OP_PARALLEL_IF_MATCH:    begin term = eq;  st_par = 1'b1; end
				OP_PARALLEL_IF_MISMATCH: begin term = !eq; st_par = 1'b1; end
				OP_SERIES_IF_MATCH:      begin term = eq;  st_ser = 1'b1; end
				OP_SERIES_IF_MISMATCH:   begin term = !eq; st_ser = 1'b1; end
				OP_START_IF_ATLEAST:     begin term = ge;  st_start = 1'b1; end
				OP_START_IF_BELOW:       begin term = !ge; st_start = 1'b1; end
				OP_PARALLEL_IF_ATLEAST:  begin term = ge;  st_par = 1'b1; end
				OP_COIL_OUT,
				OP_PARALLEL_COIL_DRIVE,
				OP_RISING_EDGE_PULSE,
				OP_LATCH_SET,
				OP_LATCH_CLEAR,
				OP_OUTPUT_PAUSE:         st_coil = 1'b1;
			endcase
		end
	end

	logic_stack #(
		.DEPTH       (STACK_DEPTH)
	) u_stack (
		.clk_i       (clk_i),
		.rst_n_i     (rst_n),
		.ce_i        (ce_i),
		.start_i     (st_start),
		.par_i       (st_par),
		.ser_i       (st_ser),
		.coil_i      (st_coil),
		.term_i      (term),
		.clear_err_i (scan_start_i),
		.top_o       (top),
		.err_o       (stack_error_o)
	);

	// pause range decode over the physical outputs only
	genvar k;
	generate
		for (k = 0; k < NO; k++)
		begin : g_pause
			assign pause_hit[k] = (AW'(k) >= point_i) && (AW'(k) <= hi_pt);
		end
	endgenerate

	// coil writes; a coil reads the rung top left by earlier contacts
	always_comb
	begin
		wr                 = 1'b0;
		wr_lo              = point_i;
		wr_hi              = point_i;
		wr_val             = top;
		next_or_acc        = scan_start_i ? '0 : or_acc;
		next_prev_rung     = prev_rung;
		next_pause_acc     = scan_start_i ? PAUSE_RESET : pause_acc;
		next_operand_error = scan_start_i ? 1'b0 : operand_error_o;
		if (take)
		begin
			unique case (op_i)
				OP_COIL_OUT:
					wr = 1'b1;
				OP_PARALLEL_COIL_DRIVE:
				begin
					wr                   = 1'b1;
					wr_val               = next_or_acc[point_i] | top;
					next_or_acc[point_i] = wr_val;
				end
				OP_RISING_EDGE_PULSE:
				begin
					wr                      = 1'b1;
					wr_val                  = top && !prev_rung[point_i];
					next_prev_rung[point_i] = top;
				end
				OP_LATCH_SET:
				begin
					wr     = top;
					wr_hi  = hi_pt;
					wr_val = 1'b1;
				end
				OP_LATCH_CLEAR:
				begin
					wr     = top;
					wr_hi  = hi_pt;
					wr_val = 1'b0;
				end
				OP_OUTPUT_PAUSE:
				begin
					if (top)
						next_pause_acc = next_pause_acc | pause_hit;
					if (hi_pt > AW'(PAUSE_LAST))
						next_operand_error = 1'b1;
				end
				default: ; // contacts and no-op leave the image alone
			endcase
		end
	end

	point_memory #(
		.AW        (AW),
		.N         (N)
	) u_image (
		.clk_i     (clk_i),
		.rst_n_i   (rst_n),
		.ce_i      (ce_i),
		.wr_i      (wr),
		.wr_lo_i   (wr_lo),
		.wr_hi_i   (wr_hi),
		.wr_val_i  (wr_val),
		.rd_addr_i (image_addr_i),
		.rd_bit_o  (image_bit_o),
		.bits_o    (img)
	);

	// pins only move at scan end so mid-scan coil glitches never escape
	always_comb
	begin
		next_outputs = outputs_o;
		if (scan_end_i)
			next_outputs = img[NO-1:0] & ~(pause_acc & ~override_i);
	end

	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			or_acc          <= '0;
			prev_rung       <= '0;
			pause_acc       <= PAUSE_RESET;
			outputs_o       <= OUTS_RESET;
			operand_error_o <= 1'b0;
		end
		else if (ce_i)
		begin
			or_acc          <= next_or_acc;
			prev_rung       <= next_prev_rung;
			pause_acc       <= next_pause_acc;
			outputs_o       <= next_outputs;
			operand_error_o <= next_operand_error;
		end
	end

	or_drive_on_a: assert property (@(posedge clk_i) disable iff (!rst_n)
		(ce_i && take && op_i == OP_PARALLEL_COIL_DRIVE && top)
		|=> img[$past(point_i)])
		else $error("wired-or coil not on");

	pulse_one_scan_a: assert property (@(posedge clk_i) disable iff (!rst_n)
		(ce_i && take && op_i == OP_RISING_EDGE_PULSE && !scan_start_i
		&& prev_rung[point_i]) |=> !img[$past(point_i)])
		else $error("pulse held past one scan");

	latch_set_a: assert property (@(posedge clk_i) disable iff (!rst_n)
		(ce_i && take && op_i == OP_LATCH_SET && top)
		|=> img[$past(point_i)] && img[$past(hi_pt)])
		else $error("latch set missed a point");

	latch_clear_a: assert property (@(posedge clk_i) disable iff (!rst_n)
		(ce_i && take && op_i == OP_LATCH_CLEAR && top)
		|=> !img[$past(point_i)] && !img[$past(hi_pt)])
		else $error("clear missed a point");

	pause_force_a: assert property (@(posedge clk_i) disable iff (!rst_n)
		(ce_i && scan_end_i)
		|=> (outputs_o & $past(pause_acc & ~override_i)) == 8'h00)
		else $error("paused output driven");

	pause_override_a: assert property (@(posedge clk_i) disable iff (!rst_n)
		(ce_i && scan_end_i)
		|=> (outputs_o & $past(override_i)) == $past(img[NO-1:0] & override_i))
		else $error("override output not updated");

	magnitude_start_a: assert property (@(posedge clk_i) disable iff (!rst_n)
		(ce_i && take && op_i == OP_START_IF_BELOW) |=> top == !$past(ge))
		else $error("below contact wrong");

	unsigned_cmp_a: assert property (@(posedge clk_i) disable iff (!rst_n)
		(ce_i && take && op_i == OP_START_IF_ATLEAST)
		|=> top == ($past(operand_a_i) >= $past(operand_b_i)))
		else $error("at-least contact wrong");

	last_coil_a: assert property (@(posedge clk_i) disable iff (!rst_n)
		(ce_i && take && op_i == OP_COIL_OUT) |=> img[$past(point_i)] == $past(top))
		else $error("plain coil did not take rung");

	scan_clear_a: assert property (@(posedge clk_i) disable iff (!rst_n)
		(ce_i && scan_start_i && !take) |=> or_acc == '0)
		else $error("wired-or terms not cleared");
endmodule // ladder_rung_evaluator
`default_nettype wire

//--- verif/ladder_rung_evaluator_tb.sv
// self-checking bench of the rung evaluator
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) \
	begin \
		total_checks++; \
		if ((g) !== (e)) \
		begin \
			num_errors++; \
			$display("[FAIL] %s exp %0h got %0h", nm, e, g); \
		end \
	end
module ladder_rung_evaluator_tb
	import rung_pkg::*;
;
	logic        clk_i, resetn_i, ce_i, scan_start_i, scan_end_i;
	logic        instr_valid_i, range_en_i;
	op_e         op_i;
	logic [15:0] operand_a_i, operand_b_i;
	logic [7:0]  point_i, range_end_i, override_i, image_addr_i;
	logic        image_bit_o, rung_o, stack_error_o, operand_error_o;
	logic [7:0]  outputs_o, o;
	logic        b;
	int          num_errors, total_checks, cycles;

	ladder_rung_evaluator u_dut (
		.clk_i, .resetn_i, .ce_i, .scan_start_i, .scan_end_i,
		.instr_valid_i, .op_i, .operand_a_i, .operand_b_i, .point_i,
		.range_en_i, .range_end_i, .override_i, .image_addr_i,
		.image_bit_o, .outputs_o, .rung_o, .stack_error_o,
		.operand_error_o
	);

	// free running 125 MHz clock
	initial
	begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end

	// hang guard: whole run needs well under a thousand cycles
	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			num_errors++;
			give_verdict();
		end
	end

	task automatic give_verdict();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// valid is left high so back to back instructions need no gap
	task automatic instr(input op_e c, input logic [15:0] a, bb,
		input logic [7:0] p = 8'h00, input logic [7:0] e = 8'h00);
		op_i = c;
		operand_a_i = a;
		operand_b_i = bb;
		point_i = p;
		range_en_i = (e != 8'h00);
		range_end_i = e;
		instr_valid_i = 1'b1;
		@(negedge clk_i);
	endtask

	task automatic rung(input logic v);
		instr(OP_START_IF_MATCH, 16'h0001, v ? 16'h0001 : 16'h0002);
	endtask

	task automatic coil(input op_e c, input logic [7:0] p,
		input logic [7:0] e = 8'h00);
		instr(c, 16'h0000, 16'h0000, p, e);
	endtask

	task automatic scan_begin();
		instr_valid_i = 1'b0;
		scan_start_i = 1'b1;
		@(negedge clk_i);
		scan_start_i = 1'b0;
	endtask

	// one idle cycle first so the last image write has landed
	task automatic scan_finish();
		instr_valid_i = 1'b0;
		@(negedge clk_i);
		scan_end_i = 1'b1;
		@(negedge clk_i);
		scan_end_i = 1'b0;
		o = outputs_o;
	endtask

	task automatic rd(input logic [7:0] ad);
		instr_valid_i = 1'b0;
		image_addr_i = ad;
		@(negedge clk_i);
		@(negedge clk_i);
		b = image_bit_o;
	endtask

	task automatic cc(input op_e c1, input logic [15:0] a1, b1,
		input op_e c2, input logic [15:0] a2, b2, input logic e);
		scan_begin();
		instr(c1, a1, b1);
		if (c2 != OP_NOP)
			instr(c2, a2, b2);
		`CHK("rung", e, rung_o)
		// close the rung so the next start opens a fresh one, not a branch
		coil(OP_COIL_OUT, 8'hff);
	endtask

	task automatic t_compare();
		cc(OP_START_IF_MATCH, 16'hffff, 16'hffff, OP_NOP, 16'h0, 16'h0, 1);
		cc(OP_START_IF_MATCH, 16'hffff, 16'h0000, OP_NOP, 16'h0, 16'h0, 0);
		cc(OP_START_IF_MISMATCH, 16'h5, 16'h6, OP_NOP, 16'h0, 16'h0, 1);
		cc(OP_START_IF_MISMATCH, 16'h5, 16'h5, OP_NOP, 16'h0, 16'h0, 0);
		cc(OP_START_IF_MATCH, 16'h1, 16'h2, OP_PARALLEL_IF_MATCH, 16'h3, 16'h3, 1);
		cc(OP_START_IF_MATCH, 16'h1, 16'h2, OP_PARALLEL_IF_MATCH, 16'h3, 16'h4, 0);
		cc(OP_START_IF_MATCH, 16'h1, 16'h2, OP_PARALLEL_IF_MISMATCH, 16'h3, 16'h4, 1);
		cc(OP_START_IF_MATCH, 16'h1, 16'h1, OP_SERIES_IF_MATCH, 16'h3, 16'h4, 0);
		cc(OP_START_IF_MATCH, 16'h1, 16'h1, OP_SERIES_IF_MATCH, 16'h3, 16'h3, 1);
		cc(OP_START_IF_MATCH, 16'h1, 16'h1, OP_SERIES_IF_MISMATCH, 16'h3, 16'h3, 0);
		cc(OP_START_IF_ATLEAST, 16'h4, 16'h4, OP_NOP, 16'h0, 16'h0, 1);
		cc(OP_START_IF_ATLEAST, 16'h8000, 16'h7fff, OP_NOP, 16'h0, 16'h0, 1);
		cc(OP_START_IF_BELOW, 16'h0001, 16'hffff, OP_NOP, 16'h0, 16'h0, 1);
		cc(OP_START_IF_BELOW, 16'h5, 16'h5, OP_NOP, 16'h0, 16'h0, 0);
		cc(OP_START_IF_MATCH, 16'h1, 16'h2, OP_PARALLEL_IF_ATLEAST, 16'h3, 16'h4, 0);
		cc(OP_START_IF_MATCH, 16'h1, 16'h2, OP_PARALLEL_IF_ATLEAST, 16'hffff, 16'h1, 1);
		$display("compare contacts done");
	endtask

	// last rung false: a plain write would leave the point off
	task automatic t_coils();
		scan_begin();
		rung(1'b1);
		coil(OP_PARALLEL_COIL_DRIVE, 8'h01);
		rung(1'b0);
		coil(OP_PARALLEL_COIL_DRIVE, 8'h01);
		rung(1'b1);
		coil(OP_RISING_EDGE_PULSE, 8'h00);
		scan_finish();
		`CHK("wired_or", 1'b1, o[1])
		`CHK("pulse_on", 1'b1, o[0])
		scan_begin();
		rung(1'b0);
		coil(OP_PARALLEL_COIL_DRIVE, 8'h01);
		rung(1'b1);
		coil(OP_RISING_EDGE_PULSE, 8'h00);
		scan_finish();
		`CHK("wired_off", 1'b0, o[1])
		`CHK("pulse_off", 1'b0, o[0])
		scan_begin();
		rung(1'b1);
		coil(OP_COIL_OUT, 8'h00);
		rung(1'b0);
		coil(OP_COIL_OUT, 8'h00);
		scan_finish();
		`CHK("last_coil", 1'b0, o[0])
		// enable low: a true start contact must leave the rung top alone
		ce_i = 1'b0;
		rung(1'b1);
		`CHK("ce_hold", 1'b0, rung_o)
		ce_i = 1'b1;
		$display("coils done");
	endtask

	task automatic t_latch();
		scan_begin();
		rung(1'b1);
		coil(OP_LATCH_SET, 8'h02, 8'h04);
		coil(OP_LATCH_SET, 8'h64, 8'h66);
		scan_finish();
		`CHK("set", 3'b111, o[4:2])
		rd(8'h65);
		`CHK("set_img", 1'b1, b)
		scan_begin();
		rung(1'b0);
		coil(OP_LATCH_CLEAR, 8'h02, 8'h04);
		rung(1'b1);
		coil(OP_LATCH_CLEAR, 8'h03);
		scan_finish();
		`CHK("clear", 3'b101, o[4:2])
		scan_begin();
		rung(1'b0);
		coil(OP_LATCH_SET, 8'h03);
		scan_finish();
		`CHK("held", 3'b101, o[4:2])
		$display("latch done");
	endtask

	task automatic t_pause();
		override_i = 8'h40;
		scan_begin();
		rung(1'b1);
		coil(OP_LATCH_SET, 8'h05, 8'h07);
		coil(OP_OUTPUT_PAUSE, 8'h05, 8'h07);
		scan_finish();
		`CHK("pause", 3'b010, o[7:5])
		rd(8'h07);
		`CHK("pause_img", 1'b1, b)
		scan_begin();
		rung(1'b1);
		coil(OP_OUTPUT_PAUSE, 8'h06, 8'h08);
		`CHK("operr", 1'b1, operand_error_o)
		scan_finish();
		`CHK("pause_wide", 3'b011, o[7:5])
		override_i = 8'h00;
		scan_begin();
		`CHK("operr_clr", 1'b0, operand_error_o)
		scan_finish();
		`CHK("unpaused", 3'b111, o[7:5])
		$display("pause done");
	endtask

	task automatic t_stack();
		scan_begin();
		repeat (8) rung(1'b1);
		`CHK("stack8", 1'b0, stack_error_o)
		rung(1'b1);
		`CHK("stack9", 1'b1, stack_error_o)
		scan_begin();
		`CHK("stack_clr", 1'b0, stack_error_o)
		$display("stack done");
	endtask

	// main sequence
	initial
	begin
		{resetn_i, scan_start_i, scan_end_i, instr_valid_i} = 4'h0;
		{range_en_i, operand_a_i, operand_b_i} = 33'h0;
		{point_i, range_end_i, override_i, image_addr_i} = 32'h0;
		ce_i = 1'b1;
		op_i = OP_NOP;
		repeat (2) @(negedge clk_i);
		resetn_i = 1'b1;
		repeat (3) @(negedge clk_i);
		`CHK("outs_rst", OUTS_RESET, outputs_o)
		`CHK("err_rst", 1'b0, stack_error_o)
		t_compare();
		t_coils();
		t_latch();
		t_pause();
		t_stack();
		give_verdict();
	end
endmodule // ladder_rung_evaluator_tb
`default_nettype wire
